/* File: fan_cruise_pkg.sv */
package fan_cruise_pkg;
   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFF_SYS_VALUE = 8'h01;
   localparam logic [7:0] OFF_PROC_VALUE = 8'h03;
   localparam logic [7:0] OFF_FAN_CONFIG_FIRST = 8'h04;
   localparam logic [7:0] OFF_SYS_STOP_VALUE = 8'h08;
   localparam logic [7:0] OFF_PROC_STOP_VALUE = 8'h09;
   localparam logic [7:0] OFF_STEP_DOWN_TIME = 8'h0e;
   localparam logic [7:0] OFF_STEP_UP_TIME = 8'h0f;
   localparam logic [7:0] OFF_AUX_VALUE = 8'h11;
   localparam logic [7:0] OFF_FAN_CONFIG_SECOND = 8'h12;
   localparam logic [7:0] OFF_AUX_STOP_VALUE = 8'h15;
   localparam logic [7:0] OFF_AUX_STARTUP_VALUE = 8'h16;
   localparam logic [7:0] OFF_AUX_STOP_TIME = 8'h17;
   localparam logic [7:0] OFF_OUTPUT_TYPE = 8'h18;
   localparam logic [7:0] OFF_STATUS = 8'h19;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int BIT_SYS_HOLD = 5;
   localparam int BIT_PROC_HOLD = 4;
   localparam int BIT_AUX_HOLD = 3;
   localparam int BIT_AUX_MODE_LO = 1;
   localparam int BIT_AUX_PWM_SELECT = 6;
   // ------------------------------------------------------------
   // Values after reset
   // ------------------------------------------------------------
   localparam logic [7:0] RST_FAN_CONFIG_SECOND = 8'h00;
   localparam logic [7:0] RST_FAN_CONFIG_FIRST = 8'h00;
   localparam logic [7:0] RST_STOP_VALUE = 8'h01;
   localparam logic [7:0] RST_STARTUP_VALUE = 8'h01;
   localparam logic [7:0] RST_STOP_TIME = 8'h3c;
   localparam logic [7:0] RST_STEP_TIME = 8'h0a;
   localparam logic [7:0] RST_FAN_VALUE = 8'hff;
   localparam logic [7:0] RST_OUTPUT_TYPE = 8'h40;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam longint CLOCK_HZ = 200000000;
   localparam longint PWM_UNIT_MS = 100;
   localparam longint DC_UNIT_MS = 1600;
   localparam longint PWM_UNIT_CYCLES = CLOCK_HZ / 1000 * PWM_UNIT_MS;
   localparam longint DC_UNIT_CYCLES = CLOCK_HZ / 1000 * DC_UNIT_MS;
   // ------------------------------------------------------------
   // Modes
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_MANUAL = 2'b00,
      MODE_THERMAL = 2'b01,
      MODE_SPEED = 2'b10,
      MODE_RESERVED = 2'b11
   } aux_mode_t;
endpackage

/* File: fan_unit_tick.sv */
`timescale 1ns/1ps
module fan_unit_tick #(
   parameter longint PWM_CYCLES = fan_cruise_pkg::PWM_UNIT_CYCLES,
   parameter longint DC_CYCLES = fan_cruise_pkg::DC_UNIT_CYCLES
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Unit select and tick
   input wire logic pwm_select,
   output logic tick
);
   typedef struct packed {
      logic [31:0] count;
      logic tick;
   } tick_state_t;
   tick_state_t state;
   tick_state_t next_state;
   logic [31:0] limit;

   // ------------------------------------------------------------
   // Prescaler: the output type picks the unit length
   // ------------------------------------------------------------
   always_comb begin
      limit = pwm_select ? 32'(PWM_CYCLES - 1) : 32'(DC_CYCLES - 1);
      next_state = state;
      next_state.tick = 1'b0;
      if (state.count >= limit) begin
         next_state.count = 32'h0;
         next_state.tick = 1'b1;
      end else begin
         next_state.count = state.count + 32'h1;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign tick = state.tick;
endmodule

/* File: fan_channel.sv */
`timescale 1ns/1ps
module fan_channel (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Control
   input wire logic tick,
   input wire logic tracking,
   input wire logic above_target,
   input wire logic below_target,
   input wire logic hold_min,
   input wire logic [7:0] manual_value,
   input wire logic [7:0] stop_value,
   input wire logic [7:0] startup_value,
   input wire logic [7:0] stop_time,
   input wire logic [7:0] step_down_time,
   input wire logic [7:0] step_up_time,
   // Output
   output logic [7:0] fan_value,
   output logic stopping
);
   typedef struct packed {
      logic [7:0] value;
      logic [7:0] step_count;
      logic [7:0] stop_count;
      logic stopping;
   } chan_state_t;
   chan_state_t state;
   chan_state_t next_state;

   // ------------------------------------------------------------
   // Ramp logic; outside tracking the manual value drives out
   // ------------------------------------------------------------
   always_comb begin
      next_state = state;
      if (!tracking) begin
         next_state.value = manual_value;
         next_state.step_count = 8'h0;
         next_state.stopping = 1'b0;
      end else if (above_target) begin
         next_state.stopping = 1'b0;
         if (state.value == 8'h0) begin
            next_state.value = startup_value;
            next_state.step_count = 8'h0;
         end else if (tick) begin
            if (state.step_count + 8'h1 >= step_up_time) begin
               next_state.step_count = 8'h0;
               if (state.value != 8'hff) begin
                  next_state.value = state.value + 8'h1;
               end
            end else begin
               next_state.step_count = state.step_count + 8'h1;
            end
         end
      end else if (below_target) begin
         if (state.value > stop_value && tick) begin
            if (state.step_count + 8'h1 >= step_down_time) begin
               next_state.step_count = 8'h0;
               next_state.value = state.value - 8'h1;
            end else begin
               next_state.step_count = state.step_count + 8'h1;
            end
         end else if (state.value < stop_value && state.value != 8'h0 && hold_min) begin
            next_state.value = stop_value;
         end else if (state.value <= stop_value && !hold_min && state.value != 8'h0) begin
            // Hold at the floor for the stop time, then drop to zero
            if (!state.stopping) begin
               next_state.stopping = 1'b1;
               next_state.stop_count = stop_time;
            end else if (state.stop_count == 8'h0) begin
               next_state.value = 8'h0;
               next_state.stopping = 1'b0;
            end else if (tick) begin
               next_state.stop_count = state.stop_count - 8'h1;
            end
         end else begin
            next_state.stopping = 1'b0;
         end
      end else begin
         // Back in range: a later stop must reload its count, not resume a stale one
         next_state.stopping = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign fan_value = state.value;
   assign stopping = state.stopping;
endmodule

/* File: fan_output_cruise_limits.sv */
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
module fan_output_cruise_limits #(
   parameter longint PWM_CYCLES = fan_cruise_pkg::PWM_UNIT_CYCLES,
   parameter longint DC_CYCLES = fan_cruise_pkg::DC_UNIT_CYCLES
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Register port
   input wire logic [7:0] address,
   input wire logic [7:0] write_data,
   input wire logic write_strobe,
   input wire logic read_strobe,
   output logic [7:0] read_data,
   // Temperature and speed comparison pins
   input wire logic [2:0] above_target_pin,
   input wire logic [2:0] below_target_pin,
   // Fan outputs
   output logic [7:0] system_fan_output,
   output logic [7:0] processor_fan_output,
   output logic [7:0] auxiliary_fan_output,
   output logic aux_output_pwm
);
   typedef struct packed {
      logic [7:0] fan_config_first;
      logic [7:0] fan_config_second;
      logic [7:0] sys_value;
      logic [7:0] proc_value;
      logic [7:0] aux_value;
      logic [7:0] sys_stop_value;
      logic [7:0] proc_stop_value;
      logic [7:0] aux_fan_stop_value;
      logic [7:0] aux_fan_startup_value;
      logic [7:0] aux_fan_stop_time;
      logic [7:0] step_down_time;
      logic [7:0] step_up_time;
      logic [7:0] output_type;
      logic [7:0] read_data;
      logic [2:0] above_sync1;
      logic [2:0] above_sync2;
      logic [2:0] below_sync1;
      logic [2:0] below_sync2;
   } top_state_t;
   top_state_t state;
   top_state_t next_state;
   logic tick;
   logic [2:0] tracking;
   logic [2:0] hold_min;
   logic [2:0] stopping;
   logic [7:0] fan_value [3];
   logic [7:0] manual_value [3];
   logic [7:0] stop_value [3];
   logic [7:0] stop_time [3];
   logic [7:0] startup_value [3];

   // Tracking only for 01 and 10; 11 behaves as manual
   function automatic logic is_tracking(input logic [1:0] mode);
      case (fan_cruise_pkg::aux_mode_t'(mode))
         fan_cruise_pkg::MODE_THERMAL: is_tracking = 1'b1;
         fan_cruise_pkg::MODE_SPEED: is_tracking = 1'b1;
         default: is_tracking = 1'b0;
      endcase
   endfunction

   // ------------------------------------------------------------
   // Register file and pin synchronisers
   // ------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_state.above_sync1 = above_target_pin;
      next_state.above_sync2 = state.above_sync1;
      next_state.below_sync1 = below_target_pin;
      next_state.below_sync2 = state.below_sync1;
      if (write_strobe) begin
         case (address)
            fan_cruise_pkg::OFF_SYS_VALUE: next_state.sys_value = write_data;
            fan_cruise_pkg::OFF_PROC_VALUE: next_state.proc_value = write_data;
            fan_cruise_pkg::OFF_FAN_CONFIG_FIRST: next_state.fan_config_first = write_data;
            fan_cruise_pkg::OFF_SYS_STOP_VALUE: next_state.sys_stop_value = write_data;
            fan_cruise_pkg::OFF_PROC_STOP_VALUE: next_state.proc_stop_value = write_data;
            fan_cruise_pkg::OFF_STEP_DOWN_TIME: next_state.step_down_time = write_data;
            fan_cruise_pkg::OFF_STEP_UP_TIME: next_state.step_up_time = write_data;
            fan_cruise_pkg::OFF_AUX_VALUE: next_state.aux_value = write_data;
            fan_cruise_pkg::OFF_FAN_CONFIG_SECOND: next_state.fan_config_second = write_data;
            fan_cruise_pkg::OFF_AUX_STOP_VALUE: next_state.aux_fan_stop_value = write_data;
            fan_cruise_pkg::OFF_AUX_STARTUP_VALUE: begin
               next_state.aux_fan_startup_value = write_data;
            end
            fan_cruise_pkg::OFF_AUX_STOP_TIME: next_state.aux_fan_stop_time = write_data;
            fan_cruise_pkg::OFF_OUTPUT_TYPE: next_state.output_type = write_data;
            default: next_state.read_data = state.read_data;
         endcase
      end
      next_state.read_data = 8'h00;
      if (read_strobe) begin
         case (address)
            fan_cruise_pkg::OFF_SYS_VALUE: next_state.read_data = state.sys_value;
            fan_cruise_pkg::OFF_PROC_VALUE: next_state.read_data = state.proc_value;
            fan_cruise_pkg::OFF_FAN_CONFIG_FIRST: begin
               next_state.read_data = state.fan_config_first & 8'h3c;
            end
            fan_cruise_pkg::OFF_SYS_STOP_VALUE: next_state.read_data = state.sys_stop_value;
            fan_cruise_pkg::OFF_PROC_STOP_VALUE: next_state.read_data = state.proc_stop_value;
            fan_cruise_pkg::OFF_STEP_DOWN_TIME: next_state.read_data = state.step_down_time;
            fan_cruise_pkg::OFF_STEP_UP_TIME: next_state.read_data = state.step_up_time;
            fan_cruise_pkg::OFF_AUX_VALUE: next_state.read_data = state.aux_value;
            fan_cruise_pkg::OFF_FAN_CONFIG_SECOND: begin
               // Reserved bits 7, 6 and 0 read as zero
               next_state.read_data = state.fan_config_second & 8'h3e;
            end
            fan_cruise_pkg::OFF_AUX_STOP_VALUE: next_state.read_data = state.aux_fan_stop_value;
            fan_cruise_pkg::OFF_AUX_STARTUP_VALUE: begin
               next_state.read_data = state.aux_fan_startup_value;
            end
            fan_cruise_pkg::OFF_AUX_STOP_TIME: next_state.read_data = state.aux_fan_stop_time;
            fan_cruise_pkg::OFF_OUTPUT_TYPE: next_state.read_data = state.output_type & 8'h40;
            fan_cruise_pkg::OFF_STATUS: next_state.read_data = {5'h00, stopping};
            default: next_state.read_data = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state <= '0;
         state.fan_config_first <= fan_cruise_pkg::RST_FAN_CONFIG_FIRST;
         state.fan_config_second <= fan_cruise_pkg::RST_FAN_CONFIG_SECOND;
         state.sys_value <= fan_cruise_pkg::RST_FAN_VALUE;
         state.proc_value <= fan_cruise_pkg::RST_FAN_VALUE;
         state.aux_value <= fan_cruise_pkg::RST_FAN_VALUE;
         state.sys_stop_value <= fan_cruise_pkg::RST_STOP_VALUE;
         state.proc_stop_value <= fan_cruise_pkg::RST_STOP_VALUE;
         state.aux_fan_stop_value <= fan_cruise_pkg::RST_STOP_VALUE;
         state.aux_fan_startup_value <= fan_cruise_pkg::RST_STARTUP_VALUE;
         state.aux_fan_stop_time <= fan_cruise_pkg::RST_STOP_TIME;
         state.step_down_time <= fan_cruise_pkg::RST_STEP_TIME;
         state.step_up_time <= fan_cruise_pkg::RST_STEP_TIME;
         state.output_type <= fan_cruise_pkg::RST_OUTPUT_TYPE;
      end else begin
         state <= next_state;
      end
   end

   // ------------------------------------------------------------
   // Channel wiring
   // ------------------------------------------------------------
   assign aux_output_pwm = state.output_type[fan_cruise_pkg::BIT_AUX_PWM_SELECT];
   assign tracking[0] = is_tracking(state.fan_config_first[3:2]);
   assign tracking[1] = is_tracking(state.fan_config_first[5:4]);
   assign tracking[2] = is_tracking(state.fan_config_second[2:1]);
   assign hold_min[0] = state.fan_config_second[fan_cruise_pkg::BIT_SYS_HOLD];
   assign hold_min[1] = state.fan_config_second[fan_cruise_pkg::BIT_PROC_HOLD];
   assign hold_min[2] = state.fan_config_second[fan_cruise_pkg::BIT_AUX_HOLD];
   assign manual_value[0] = state.sys_value;
   assign manual_value[1] = state.proc_value;
   assign manual_value[2] = state.aux_value;
   assign stop_value[0] = state.sys_stop_value;
   assign stop_value[1] = state.proc_stop_value;
   assign stop_value[2] = state.aux_fan_stop_value;
   assign startup_value[0] = state.aux_fan_startup_value;
   assign startup_value[1] = state.aux_fan_startup_value;
   assign startup_value[2] = state.aux_fan_startup_value;
   assign stop_time[0] = state.aux_fan_stop_time;
   assign stop_time[1] = state.aux_fan_stop_time;
   assign stop_time[2] = state.aux_fan_stop_time;

   // One shared unit tick; its length follows the auxiliary output type
   fan_unit_tick #(
      .PWM_CYCLES(PWM_CYCLES),
      .DC_CYCLES(DC_CYCLES)
   ) u_tick (
      .clock(clock),
      .rst_n(rst_n),
      .pwm_select(aux_output_pwm),
      .tick(tick)
   );

   genvar i;
   generate
      for (i = 0; i < 3; i++) begin : g_chan
         fan_channel u_chan (
            .clock(clock),
            .rst_n(rst_n),
            .tick(tick),
            .tracking(tracking[i]),
            .above_target(state.above_sync2[i]),
            .below_target(state.below_sync2[i]),
            .hold_min(hold_min[i]),
            .manual_value(manual_value[i]),
            .stop_value(stop_value[i]),
            .startup_value(startup_value[i]),
            .stop_time(stop_time[i]),
            .step_down_time(state.step_down_time),
            .step_up_time(state.step_up_time),
            .fan_value(fan_value[i]),
            .stopping(stopping[i])
         );
      end
   endgenerate

   assign system_fan_output = fan_value[0];
   assign processor_fan_output = fan_value[1];
   assign auxiliary_fan_output = fan_value[2];
   assign read_data = state.read_data;
endmodule

/* File: fan_thermal_model.sv */
`timescale 1ns/1ps
module fan_thermal_model (
   // Clock
   input wire logic clock,
   // Commanded conditions per fan
   input wire logic [2:0] hot,
   input wire logic [2:0] cold,
   // Comparison pins
   output logic [2:0] above_target_pin,
   output logic [2:0] below_target_pin
);
   // ------------------------------------------------------------
   // Sensor lag
   // ------------------------------------------------------------
   // Sensors settle slowly, so the pins trail the command by two cycles
   logic [2:0] hot_q;
   logic [2:0] cold_q;
   always_ff @(posedge clock) begin
      hot_q <= hot;
      cold_q <= cold;
      above_target_pin <= hot_q;
      below_target_pin <= cold_q;
   end
endmodule

/* File: fan_cruise_checker.sv */
`timescale 1ns/1ps
module fan_cruise_checker #(
   parameter longint PWM_CYCLES = fan_cruise_pkg::PWM_UNIT_CYCLES,
   parameter longint DC_CYCLES = fan_cruise_pkg::DC_UNIT_CYCLES
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Register port
   input wire logic [7:0] address,
   input wire logic [7:0] write_data,
   input wire logic write_strobe,
   input wire logic read_strobe,
   input wire logic [7:0] read_data,
   // Fan outputs
   input wire logic [7:0] system_fan_output,
   input wire logic [7:0] auxiliary_fan_output,
   input wire logic aux_output_pwm
);
   // ------------------------------------------------------------
   // Shadow registers
   // ------------------------------------------------------------
   logic [7:0] cfg1, cfg2, sys_stop, aux_stop, stop_time, out_type;
   longint dwell, unit, lo, hi;
   logic mapped, aux_track;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cfg1 <= 8'h00;
         cfg2 <= 8'h00;
         sys_stop <= 8'h01;
         aux_stop <= 8'h01;
         stop_time <= 8'h3c;
         out_type <= 8'h40;
      end else if (write_strobe) begin
         case (address)
            8'h04: cfg1 <= write_data;
            8'h08: sys_stop <= write_data;
            8'h12: cfg2 <= write_data;
            8'h15: aux_stop <= write_data;
            8'h17: stop_time <= write_data;
            8'h18: out_type <= write_data;
            default: ;
         endcase
      end
   end
   // Cycles spent at the stop value; the prescaler phase is unknown, so a unit of slack
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         dwell <= 0;
      end else begin
         dwell <= (auxiliary_fan_output == aux_stop) ? dwell + 1 : 0;
      end
   end
   assign mapped = address inside {8'h01, 8'h03, 8'h04, 8'h08, 8'h09, 8'h0e, 8'h0f,
      8'h11, 8'h12, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19};
   assign aux_track = cfg2[2:1] == 2'b01 || cfg2[2:1] == 2'b10;
   assign unit = out_type[6] ? PWM_CYCLES : DC_CYCLES;
   assign lo = (longint'(stop_time) - 1) * unit;
   assign hi = (longint'(stop_time) + 1) * unit + 8;
   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   idle_read_a: assert property (!read_strobe |=> read_data == 8'h00)
      else $error("read data not zero outside a read");
   unmapped_read_a: assert property (read_strobe && !mapped |=> read_data == 8'h00)
      else $error("unmapped read not zero");
   cfg_read_a: assert property (read_strobe && address == 8'h12 |=>
      read_data == (cfg2 & 8'h3e)) else $error("config read mismatch");
   out_type_a: assert property (write_strobe && address == 8'h18 |->
      ##2 aux_output_pwm == out_type[6]) else $error("output type not applied");
   manual_aux_a: assert property (write_strobe && address == 8'h11 && !aux_track |->
      ##2 auxiliary_fan_output == $past(write_data, 2)) else $error("manual value lost");
   aux_floor_a: assert property (aux_track && cfg2[3] && !write_strobe &&
      auxiliary_fan_output >= aux_stop |=> auxiliary_fan_output >= aux_stop)
      else $error("aux output under its floor");
   sys_floor_a: assert property ((cfg1[3:2] == 2'b01 || cfg1[3:2] == 2'b10) && cfg2[5]
      && !write_strobe && system_fan_output >= sys_stop |=> system_fan_output >= sys_stop)
      else $error("system output under its floor");
   step_size_a: assert property (aux_track && !write_strobe |=>
      auxiliary_fan_output == $past(auxiliary_fan_output)
      || auxiliary_fan_output == $past(auxiliary_fan_output) + 8'h01
      || auxiliary_fan_output + 8'h01 == $past(auxiliary_fan_output)
      || auxiliary_fan_output == 8'h00 || $past(auxiliary_fan_output) == 8'h00)
      else $error("aux output jumped while tracking");
   stop_dwell_a: assert property (aux_track && !cfg2[3] &&
      $past(auxiliary_fan_output) == aux_stop && auxiliary_fan_output == 8'h00
      |-> dwell >= lo && dwell <= hi) else $error("stop time out of range");
endmodule
bind fan_output_cruise_limits fan_cruise_checker #(
   .PWM_CYCLES(PWM_CYCLES),
   .DC_CYCLES(DC_CYCLES)
) chk (
   .clock(clock), .rst_n(rst_n), .address(address), .write_data(write_data),
   .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
   .system_fan_output(system_fan_output), .auxiliary_fan_output(auxiliary_fan_output),
   .aux_output_pwm(aux_output_pwm)
);

/* File: tb_fan_output_cruise_limits.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
   $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_fan_output_cruise_limits;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] address = 8'h00;
   logic [7:0] write_data = 8'h00;
   logic write_strobe = 1'b0;
   logic read_strobe = 1'b0;
   logic [2:0] hot = 3'h0;
   logic [2:0] cold = 3'h0;
   logic [7:0] read_data, sys_out, proc_out, aux_out;
   logic [2:0] above, below;
   logic pwm;
   int err_total = 0;
   int tests_run = 0;
   int n;
   typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;
   row_t rows [9] = '{'{8'h12, 8'hff, 8'h3e}, '{8'h12, 8'h00, 8'h00}, '{8'h15, 8'h5a, 8'h5a},
      '{8'h16, 8'ha5, 8'ha5}, '{8'h17, 8'h3c, 8'h3c}, '{8'h18, 8'hff, 8'h40},
      '{8'h30, 8'hff, 8'h00}, '{8'h0e, 8'h00, 8'h00}, '{8'h0f, 8'h00, 8'h00}};
   fan_output_cruise_limits #(.PWM_CYCLES(4), .DC_CYCLES(64)) DUT (
      .clock(clock), .rst_n(rst_n), .address(address), .write_data(write_data),
      .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
      .above_target_pin(above), .below_target_pin(below), .system_fan_output(sys_out),
      .processor_fan_output(proc_out), .auxiliary_fan_output(aux_out), .aux_output_pwm(pwm));
   fan_thermal_model env (.clock(clock), .hot(hot), .cold(cold),
      .above_target_pin(above), .below_target_pin(below));
   always #2.5 clock = ~clock;
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   function automatic logic [7:0] fan(input int i);
      return (i == 0) ? sys_out : ((i == 1) ? proc_out : aux_out);
   endfunction
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      address <= a;
      write_data <= d;
      write_strobe <= 1'b1;
      @(posedge clock);
      write_strobe <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clock);
      address <= a;
      read_strobe <= 1'b1;
      @(posedge clock);
      read_strobe <= 1'b0;
      #1;
      `CHK(read_data, e)
   endtask
   task automatic finish_test();
      $display("tests_run=%0d err_total=%0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // Bounded wait until a fan output equals x (ne clear) or leaves x (ne set)
   task automatic wait_fan(input int i, input logic [7:0] x, input bit ne, input int lim);
      n = 0;
      while (((fan(i) === x) == ne) && n < lim) begin
         @(posedge clock);
         #1;
         n++;
      end
      tests_run++;
      if ((fan(i) === x) == ne) begin
         err_total++;
         $display("FAIL t=%0t fan %0d got=%h exp=%h", $time, i, fan(i), x);
         finish_test();
      end
   endtask
   task automatic settle(input int c);
      repeat (c) @(posedge clock);
      #1;
   endtask
   // ------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------
   initial begin
      repeat (20) @(posedge clock);
      rst_n <= 1'b1;
      rd_chk(8'h12, 8'h00);
      rd_chk(8'h15, 8'h01);
      rd_chk(8'h17, 8'h3c);
      rd_chk(8'h18, 8'h40);
      $display("test reset values ended, errors %0d", err_total);
      foreach (rows[k]) begin
         wr(rows[k].a, rows[k].d);
         rd_chk(rows[k].a, rows[k].e);
      end
      $display("test register table ended, errors %0d", err_total);
      wr(8'h11, 8'h37);
      wait_fan(2, 8'h37, 0, 4);
      wr(8'h18, 8'h00);
      settle(2);
      `CHK(pwm, 1'b0)
      wr(8'h18, 8'h40);
      settle(2);
      `CHK(pwm, 1'b1)
      $display("test manual ended, errors %0d", err_total);
      wr(8'h15, 8'h05);
      wr(8'h16, 8'h20);
      wr(8'h17, 8'h03);
      wr(8'h11, 8'h08);
      cold <= 3'b100;
      wr(8'h12, 8'h02);
      wait_fan(2, 8'h05, 0, 200);
      wait_fan(2, 8'h00, 0, 200);
      `CHK(n >= 8 && n <= 24, 1'b1)
      cold <= 3'b000;
      hot <= 3'b100;
      wait_fan(2, 8'h00, 1, 100);
      `CHK(aux_out, 8'h20)
      $display("test pwm stop and start ended, errors %0d", err_total);
      hot <= 3'b000;
      cold <= 3'b100;
      wr(8'h12, 8'h00);
      wr(8'h18, 8'h00);
      wr(8'h17, 8'h02);
      wr(8'h11, 8'h06);
      wr(8'h12, 8'h02);
      wait_fan(2, 8'h05, 0, 300);
      wait_fan(2, 8'h00, 0, 400);
      `CHK(n >= 64 && n <= 200, 1'b1)
      $display("test dc stop time ended, errors %0d", err_total);
      wr(8'h18, 8'h40);
      wr(8'h12, 8'h00);
      wr(8'h11, 8'h08);
      wr(8'h0e, 8'h02);
      wr(8'h12, 8'h0a);
      wait_fan(2, 8'h05, 0, 200);
      `CHK(n >= 20 && n <= 28, 1'b1)
      settle(100);
      `CHK(aux_out, 8'h05)
      $display("test aux hold ended, errors %0d", err_total);
      wr(8'h01, 8'h06);
      wr(8'h03, 8'h06);
      wr(8'h08, 8'h04);
      wr(8'h09, 8'h03);
      wr(8'h12, 8'h20);
      cold <= 3'b011;
      wr(8'h04, 8'h14);
      wait_fan(0, 8'h04, 0, 300);
      wait_fan(1, 8'h00, 0, 300);
      settle(60);
      `CHK(sys_out, 8'h04)
      wr(8'h04, 8'h00);
      wr(8'h12, 8'h10);
      wr(8'h04, 8'h14);
      wait_fan(0, 8'h00, 0, 300);
      wait_fan(1, 8'h03, 0, 300);
      settle(60);
      `CHK(proc_out, 8'h03)
      $display("test system and processor hold ended, errors %0d", err_total);
      cold <= 3'b100;
      wr(8'h12, 8'h04);
      wait_fan(2, 8'h05, 0, 200);
      wr(8'h12, 8'h00);
      wr(8'h12, 8'h06);
      settle(60);
      `CHK(aux_out, 8'h08)
      $display("test speed and reserved modes ended, errors %0d", err_total);
      @(posedge clock);
      rst_n <= 1'b0;
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      settle(1);
      `CHK(aux_out, 8'hff)
      rd_chk(8'h12, 8'h00);
      rd_chk(8'h17, 8'h3c);
      $display("test second reset ended, errors %0d", err_total);
      finish_test();
   end
endmodule
